//--- iep_pkg.sv
package iep_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int unsigned NUM_BANKS = 3;
   localparam int unsigned BANK_W = 8;
   localparam int unsigned NUM_PINS = NUM_BANKS * BANK_W;

   // ------------------------------------------------------------
   // Command byte layout
   // ------------------------------------------------------------
   localparam int unsigned CMD_AUTO_ADVANCE_BIT = 7;
   localparam int unsigned CMD_GRP_HI = 3;
   localparam int unsigned CMD_GRP_LO = 2;
   localparam int unsigned CMD_SEL_HI = 1;
   localparam int unsigned CMD_SEL_LO = 0;

   // Register groups held in command bits 3:2
   localparam logic [1:0] GRP_PIN_LEVEL = 2'h0;
   localparam logic [1:0] GRP_DRIVE = 2'h1;
   localparam logic [1:0] GRP_INVERT = 2'h2;
   localparam logic [1:0] GRP_DIRECTION = 2'h3;

   // Bank selects held in command bits 1:0
   localparam logic [1:0] SEL_BANK0 = 2'h0;
   localparam logic [1:0] SEL_LAST = 2'h2;
   localparam logic [1:0] SEL_STEP = 2'h1;

   // Register offsets, as command codes
   localparam logic [7:0] OFS_PIN_LEVEL_BANK0 = 8'h00;
   localparam logic [7:0] OFS_PIN_LEVEL_BANK1 = 8'h01;
   localparam logic [7:0] OFS_PIN_LEVEL_BANK2 = 8'h02;
   localparam logic [7:0] OFS_DRIVE_LATCH_BANK0 = 8'h04;
   localparam logic [7:0] OFS_DRIVE_LATCH_BANK1 = 8'h05;
   localparam logic [7:0] OFS_DRIVE_LATCH_BANK2 = 8'h06;
   localparam logic [7:0] OFS_INVERT_SELECT_BANK0 = 8'h08;
   localparam logic [7:0] OFS_INVERT_SELECT_BANK1 = 8'h09;
   localparam logic [7:0] OFS_INVERT_SELECT_BANK2 = 8'h0a;
   localparam logic [7:0] OFS_DIRECTION_BANK0 = 8'h0c;
   localparam logic [7:0] OFS_DIRECTION_BANK1 = 8'h0d;
   localparam logic [7:0] OFS_DIRECTION_BANK2 = 8'h0e;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_DRIVE = 8'hff;
   localparam logic [7:0] RST_INVERT = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'hff;
   localparam logic [7:0] RST_CMD = 8'h00;
   localparam logic [7:0] RD_RESERVED = 8'h00;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      IEP_ST_CMD = 2'b01,
      IEP_ST_DATA = 2'b10
   } iep_state_t;

   typedef logic [NUM_BANKS-1:0][BANK_W-1:0] iep_bank_t;

   typedef struct packed {
      iep_bank_t drive;
      iep_bank_t invert;
      iep_bank_t dir;
   } iep_regs_t;

   // Byte-level link from the serial front end
   typedef struct packed {
      logic wr_start;
      logic wr_valid;
      logic [7:0] wr_data;
      logic rd_req;
   } iep_link_t;

   typedef struct packed {
      iep_state_t st;
      logic [7:0] cmd;
      iep_regs_t regs;
      logic [7:0] rd_data;
      logic rd_valid;
   } iep_main_state_t;

   typedef struct packed {
      logic [NUM_PINS-1:0] meta;
      logic [NUM_PINS-1:0] level;
   } iep_sync_state_t;

endpackage

//--- iep_pin_sync.sv
`timescale 1ns/1ps
module iep_pin_sync (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [iep_pkg::NUM_PINS-1:0] PIN_IN,
   output logic [iep_pkg::NUM_PINS-1:0] LEVEL
);

   iep_pkg::iep_sync_state_t st_r;
   iep_pkg::iep_sync_state_t st_nxt;

   // ------------------------------------------------------------
   // Two-stage capture of the asynchronous pin levels
   // ------------------------------------------------------------
   // The first stage feeds only the second; nothing else looks at it.
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = PIN_IN;
      st_nxt.level = st_r.meta;
   end

   // No reset value: the levels simply follow the pins
   always_ff @(posedge CLK) begin
      st_r <= st_nxt;
   end

   assign LEVEL = st_r.level;

endmodule // iep_pin_sync

//--- iep_port_regs.sv
`timescale 1ns/1ps
module iep_port_regs (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic WR_START,
   input wire logic WR_VALID,
   input wire logic [7:0] WR_DATA,
   input wire logic RD_REQ,
   output logic [7:0] RD_DATA,
   output logic RD_VALID,
   output logic [7:0] CMD_REG,
   input wire logic [iep_pkg::NUM_PINS-1:0] P_IN,
   output logic [iep_pkg::NUM_PINS-1:0] P_OUT,
   output logic [iep_pkg::NUM_PINS-1:0] P_OE
);

   iep_pkg::iep_main_state_t st_r;
   iep_pkg::iep_main_state_t st_nxt;
   iep_pkg::iep_link_t link;
   logic [iep_pkg::NUM_PINS-1:0] pin_level;
   iep_pkg::iep_bank_t reported;

   assign link = '{wr_start: WR_START, wr_valid: WR_VALID, wr_data: WR_DATA, rd_req: RD_REQ};

   // ------------------------------------------------------------
   // Pin capture
   // ------------------------------------------------------------
   iep_pin_sync iep_pin_sync_inst (
      .CLK(CLK),
      .SRST(SRST),
      .PIN_IN(P_IN),
      .LEVEL(pin_level)
   );

   // ------------------------------------------------------------
   // Reported input levels
   // ------------------------------------------------------------
   // Inversion is gated by direction so an output pin reads back true.
   always_comb begin
      reported = iep_pkg::iep_bank_t'(pin_level);
      reported = reported ^ (st_r.regs.invert & st_r.regs.dir);
   end

   // ------------------------------------------------------------
   // Command, register and read logic
   // ------------------------------------------------------------
   function automatic logic [1:0] next_sel(input logic [1:0] sel);
      next_sel = (sel >= iep_pkg::SEL_LAST) ? iep_pkg::SEL_BANK0
                                            : sel + iep_pkg::SEL_STEP;
   endfunction

   logic [1:0] grp;
   logic [1:0] sel;
   logic auto_advance_flag;
   assign grp = st_r.cmd[iep_pkg::CMD_GRP_HI:iep_pkg::CMD_GRP_LO];
   assign sel = st_r.cmd[iep_pkg::CMD_SEL_HI:iep_pkg::CMD_SEL_LO];
   assign auto_advance_flag = st_r.cmd[iep_pkg::CMD_AUTO_ADVANCE_BIT];

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_valid = 1'b0;
      if (link.wr_start) begin
         st_nxt.st = iep_pkg::IEP_ST_CMD;
      end else if (link.wr_valid) begin
         unique case (st_r.st)
            iep_pkg::IEP_ST_CMD: begin
               st_nxt.cmd = link.wr_data;
               st_nxt.st = iep_pkg::IEP_ST_DATA;
            end
            iep_pkg::IEP_ST_DATA: begin
               // Reserved select code 3 is never issued, so writes to it drop
               if (sel <= iep_pkg::SEL_LAST) begin
                  unique case (grp)
                     iep_pkg::GRP_PIN_LEVEL: ;
                     iep_pkg::GRP_DRIVE: st_nxt.regs.drive[sel] = link.wr_data;
                     iep_pkg::GRP_INVERT: st_nxt.regs.invert[sel] = link.wr_data;
                     iep_pkg::GRP_DIRECTION: st_nxt.regs.dir[sel] = link.wr_data;
                  endcase
               end
               if (auto_advance_flag) begin
                  st_nxt.cmd[iep_pkg::CMD_SEL_HI:iep_pkg::CMD_SEL_LO] = next_sel(sel);
               end
            end
            default: st_nxt.st = iep_pkg::IEP_ST_DATA;
         endcase
      end else if (link.rd_req) begin
         // Reads use whatever command the last write or auto-advancing read left behind
         st_nxt.rd_valid = 1'b1;
         st_nxt.rd_data = iep_pkg::RD_RESERVED;
         if (sel <= iep_pkg::SEL_LAST) begin
            unique case (grp)
               iep_pkg::GRP_PIN_LEVEL: st_nxt.rd_data = reported[sel];
               iep_pkg::GRP_DRIVE: st_nxt.rd_data = st_r.regs.drive[sel];
               iep_pkg::GRP_INVERT: st_nxt.rd_data = st_r.regs.invert[sel];
               iep_pkg::GRP_DIRECTION: st_nxt.rd_data = st_r.regs.dir[sel];
            endcase
         end
         if (auto_advance_flag) begin
            st_nxt.cmd[iep_pkg::CMD_SEL_HI:iep_pkg::CMD_SEL_LO] = next_sel(sel);
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         st_r.st <= iep_pkg::IEP_ST_DATA;
         st_r.cmd <= iep_pkg::RST_CMD;
         st_r.regs.drive <= {iep_pkg::NUM_BANKS{iep_pkg::RST_DRIVE}};
         st_r.regs.invert <= {iep_pkg::NUM_BANKS{iep_pkg::RST_INVERT}};
         st_r.regs.dir <= {iep_pkg::NUM_BANKS{iep_pkg::RST_DIRECTION}};
         st_r.rd_data <= iep_pkg::RD_RESERVED;
         st_r.rd_valid <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // The latch is always presented; the enable decides if it reaches the pin.
   assign P_OUT = st_r.regs.drive;
   assign P_OE = ~st_r.regs.dir;
   assign RD_DATA = st_r.rd_data;
   assign RD_VALID = st_r.rd_valid;
   assign CMD_REG = st_r.cmd;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   logic wr_data_cyc;
   logic rd_cyc;
   assign wr_data_cyc = WR_VALID && !WR_START && (st_r.st == iep_pkg::IEP_ST_DATA);
   assign rd_cyc = RD_REQ && !WR_VALID && !WR_START;

   a_oe_from_dir: assert property (
         wr_data_cyc && grp == iep_pkg::GRP_DIRECTION && sel == 2'h0
         |=> P_OE[7:0] == ~$past(WR_DATA))
      else $error("pin enable does not follow direction write");
   a_latch_on_pin: assert property (
         wr_data_cyc && grp == iep_pkg::GRP_DRIVE && sel == 2'h0
         |=> P_OUT[7:0] == $past(WR_DATA))
      else $error("output pin does not drive its latch");
   a_level_ro: assert property (
         wr_data_cyc && grp == iep_pkg::GRP_PIN_LEVEL |=> $stable(st_r.regs))
      else $error("write to input register changed state");
   a_cmd_capture: assert property (
         WR_VALID && !WR_START && st_r.st == iep_pkg::IEP_ST_CMD
         |=> CMD_REG == $past(WR_DATA) && st_r.st == iep_pkg::IEP_ST_DATA)
      else $error("command byte not stored");
   a_sel_wrap: assert property (
         (wr_data_cyc || rd_cyc) && auto_advance_flag && sel == iep_pkg::SEL_LAST
         |=> CMD_REG[1:0] == iep_pkg::SEL_BANK0)
      else $error("bank select did not wrap");
   a_sel_hold: assert property (
         (wr_data_cyc || rd_cyc) && !auto_advance_flag |=> $stable(CMD_REG))
      else $error("bank select moved without auto advance");
   a_sel_step: assert property (
         (wr_data_cyc || rd_cyc) && auto_advance_flag && sel < iep_pkg::SEL_LAST
         |=> CMD_REG[1:0] == $past(sel) + iep_pkg::SEL_STEP)
      else $error("bank select did not advance");
   a_drive_readback: assert property (
         rd_cyc && grp == iep_pkg::GRP_DRIVE && sel == 2'h1
         |=> RD_VALID && RD_DATA == $past(st_r.regs.drive[1]))
      else $error("latch read returned wrong value");
   a_level_report: assert property (
         rd_cyc && grp == iep_pkg::GRP_PIN_LEVEL && sel == 2'h0
         |=> RD_DATA == ($past(pin_level[7:0])
            ^ ($past(st_r.regs.invert[0]) & $past(st_r.regs.dir[0]))))
      else $error("input register read wrong");
   a_reset_vals: assert property (
         $fell(SRST) |-> st_r.regs.drive == '1
            && st_r.regs.invert == '0 && st_r.regs.dir == '1)
      else $error("reset values wrong");
   a_dir_write: assert property (
         wr_data_cyc && grp == iep_pkg::GRP_DIRECTION && sel == 2'h2
         |=> st_r.regs.dir[2] == $past(WR_DATA) ##1 P_OE[23:16] == ~$past(WR_DATA, 2))
      else $error("direction write not applied");

   c_out_pin: cover property (wr_data_cyc && grp == iep_pkg::GRP_DIRECTION ##1 P_OE != '0);
   c_wrap_write: cover property (wr_data_cyc && auto_advance_flag && sel == iep_pkg::SEL_LAST);
   c_inv_read: cover property (rd_cyc && grp == iep_pkg::GRP_PIN_LEVEL && st_r.regs.invert != '0);
   c_cmd_then_read: cover property (st_r.st == iep_pkg::IEP_ST_CMD && WR_VALID ##[1:4] rd_cyc);

endmodule // iep_port_regs

//--- iep_master_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Byte-level bus master seen through the serial front end
// ------------------------------------------------------------
module iep_master_model (
   input wire logic CLK,
   input wire logic RD_VALID,
   input wire logic [7:0] RD_DATA,
   output logic WR_START,
   output logic WR_VALID,
   output logic [7:0] WR_DATA,
   output logic RD_REQ
);
   initial begin
      WR_START = 1'b0;
      WR_VALID = 1'b0;
      WR_DATA = 8'h00;
      RD_REQ = 1'b0;
   end

   // Released data shows the inverse so a stale byte is never mistaken
   task automatic put(input logic st, input logic [7:0] b);
      @(negedge CLK);
      WR_START <= st;
      WR_VALID <= !st;
      WR_DATA <= b;
      @(negedge CLK);
      WR_START <= 1'b0;
      WR_VALID <= 1'b0;
      WR_DATA <= ~b;
   endtask

   // Address phase, then the command; callers pass defined codes only
   task automatic command(input logic [7:0] c);
      put(1'b1, 8'h00);
      put(1'b0, c);
   endtask

   task automatic get(output logic [7:0] d, output logic ok);
      @(negedge CLK);
      RD_REQ <= 1'b1;
      @(negedge CLK);
      RD_REQ <= 1'b0;
      ok = RD_VALID;
      d = RD_DATA;
   endtask
endmodule // iep_master_model

//--- tb.sv
`timescale 1ns/1ps
module tb;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic [23:0] ext = 24'h5a3ca5;
   logic [23:0] pins;
   logic WR_START, WR_VALID, RD_REQ, RD_VALID;
   logic [7:0] WR_DATA, RD_DATA, CMD_REG;
   logic [23:0] P_OUT, P_OE;
   int fail_count = 0;
   int checked = 0;

   always #2.5 CLK = ~CLK;
   // Driven bits follow the latch, the rest follow the outside world
   assign pins = (P_OE & P_OUT) | (~P_OE & ext);

   iep_master_model iep_master_model_inst (.CLK(CLK), .RD_VALID(RD_VALID),
      .RD_DATA(RD_DATA), .WR_START(WR_START), .WR_VALID(WR_VALID),
      .WR_DATA(WR_DATA), .RD_REQ(RD_REQ));
   iep_port_regs iep_port_regs_inst (.CLK(CLK), .SRST(SRST), .WR_START(WR_START),
      .WR_VALID(WR_VALID), .WR_DATA(WR_DATA), .RD_REQ(RD_REQ), .RD_DATA(RD_DATA),
      .RD_VALID(RD_VALID), .CMD_REG(CMD_REG), .P_IN(pins), .P_OUT(P_OUT), .P_OE(P_OE));

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   task automatic end_of_test;
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] c);
      iep_master_model_inst.command(c);
   endtask

   task automatic wr(input logic [7:0] d);
      iep_master_model_inst.put(1'b0, d);
   endtask

   task automatic rd(input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      iep_master_model_inst.get(d, ok);
      check({15'h0, ok, d}, {15'h0, 1'b1, exp});
   endtask

   initial begin
      #100us;
      fail_count++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(negedge CLK);
      SRST <= 1'b0;
      @(negedge CLK);
      check(P_OUT, 24'hffffff);
      check(P_OE, 24'h000000);
      check({16'h0, CMD_REG}, 24'h000000);
      cmd(8'h84);
      rd(8'hff);
      rd(8'hff);
      rd(8'hff);
      cmd(8'h88);
      rd(8'h00);
      rd(8'h00);
      cmd(8'h8c);
      rd(8'hff);
      cmd(8'h80);
      rd(8'ha5);
      rd(8'h3c);
      rd(8'h5a);
      rd(8'ha5);
      cmd(8'h00);
      wr(8'h12);
      rd(8'ha5);
      rd(8'ha5);
      cmd(8'h09);
      wr(8'hff);
      wr(8'h0f);
      cmd(8'h81);
      rd(8'h33);
      rd(8'h5a);
      cmd(8'h86);
      wr(8'h11);
      wr(8'h22);
      wr(8'h33);
      check(P_OUT, 24'h113322);
      check(pins, ext);
      cmd(8'h0c);
      wr(8'hf0);
      check(P_OE, 24'h00000f);
      check({16'h0, pins[7:0]}, 24'h0000a2);
      cmd(8'h08);
      wr(8'hff);
      repeat (4) @(negedge CLK);
      cmd(8'h00);
      rd(8'h52);
      cmd(8'h04);
      rd(8'h22);
      cmd(8'h0e);
      wr(8'h00);
      check({16'h0, pins[23:16]}, 24'h000011);
      @(negedge CLK);
      SRST <= 1'b1;
      @(negedge CLK);
      SRST <= 1'b0;
      check(P_OUT, 24'hffffff);
      check(P_OE, 24'h000000);
      check({16'h0, CMD_REG}, 24'h000000);
      cmd(8'h88);
      rd(8'h00);
      rd(8'h00);
      end_of_test();
   end
endmodule // tb
